//--- hdl/sense_consts.svh
`ifndef SENSE_CONSTS_SVH
`define SENSE_CONSTS_SVH

// data widths of the sense path
`define LOAD_W 12
`define OFFS_W 8
`define SENSE_W 13
`define CALC_W 15
`define SENSE_MAX 13'h1fff
`define SENSE_ZERO 13'h0000

// clock and sense settling time
`define CLK_PERIOD_NS 5
`define SETTLE_TIME_NS 2000
`define SETTLE_CNT_W 9
`define SETTLE_CYCLES 9'((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_ONE 9'h001
`define SETTLE_DONE 9'h000

// control encodings
`define POL_POSITIVE 1'b1
`define TH_ENABLED 1'b1
`define SENSE_VALID_LVL 1'b0
`define SENSE_IDLE_LVL 1'b1

// fault and status report layout
`define FAULT_W 9
`define FAULT_OTHER_W 8
`define FAULT_PREWARN_BIT 8
`define STAT_W 2
`define STAT_CH0_BIT 0
`define STAT_CH1_BIT 1

`endif

//--- hdl/sense_pkg.sv
`include "sense_consts.svh"

package sense_pkg;

	// one-hot states of the shared sense output
	typedef enum logic [3:0]
	{
		ST_IDLE = 4'b0001,
		ST_SETTLE = 4'b0010,
		ST_VALID = 4'b0100,
		ST_HOLD = 4'b1000
	} sense_state_e;

	// source routed to the sense output, {csns1_en, csns0_en}
	typedef enum logic [1:0]
	{
		SRC_OFF = 2'b00,
		SRC_CH0 = 2'b01,
		SRC_CH1 = 2'b10,
		SRC_TEMP = 2'b11
	} sense_src_e;

	typedef logic [`LOAD_W-1:0] load_t;
	typedef logic signed [`OFFS_W-1:0] offs_t;
	typedef logic [`SENSE_W-1:0] sense_t;
	typedef logic [`SETTLE_CNT_W-1:0] settle_cnt_t;

endpackage

//--- hdl/level_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser for asynchronous level inputs
module level_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// meta feeds only the second stage
	always_comb
	begin
		next_meta = d;
		next_q = meta;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= next_meta;
			q <= next_q;
		end
	end
endmodule

//--- hdl/sense_channel.sv
`timescale 1ns/1ps
`include "sense_consts.svh"

// per-channel mirrored sense value with signed random offset
module sense_channel (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic drive_on,
	input wire logic polarity_sel,
	input sense_pkg::load_t load_current,
	input sense_pkg::offs_t rand_offset,
	output logic on_state,
	output sense_pkg::sense_t mirror
);
	import sense_pkg::*;

	logic pol_active;
	logic next_on_state;
	logic next_pol_active;
	logic pol_now;
	sense_t next_mirror;
	logic signed [`CALC_W-1:0] base;
	logic signed [`CALC_W-1:0] offs;
	logic signed [`CALC_W-1:0] total;

	// polarity is latched at turn-on, so writes while off change nothing
	always_comb
	begin
		next_on_state = drive_on;
		pol_now = (drive_on && !on_state) ? polarity_sel : pol_active; // R16
		next_pol_active = pol_now; // R6
		base = $signed({{(`CALC_W-`LOAD_W){1'b0}}, load_current});
		offs = `CALC_W'(rand_offset);
		if (pol_now == `POL_POSITIVE)
		begin
			total = base + offs; // R1
		end
		else
		begin
			total = base - offs; // R2
		end
		// clamp: the sense pin can only sink current, up to full scale
		if (!drive_on)
		begin
			next_mirror = `SENSE_ZERO;
		end
		else if (total < 0)
		begin
			next_mirror = `SENSE_ZERO;
		end
		else if (total > $signed({2'b00, `SENSE_MAX}))
		begin
			next_mirror = `SENSE_MAX;
		end
		else
		begin
			next_mirror = total[`SENSE_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			on_state <= 1'b0;
			pol_active <= 1'b0;
			mirror <= `SENSE_ZERO;
		end
		else
		begin
			on_state <= next_on_state;
			pol_active <= next_pol_active;
			mirror <= next_mirror;
		end
	end
endmodule

//--- hdl/sense_offset_status_logic.sv
`timescale 1ns/1ps
`include "sense_consts.svh"

// Overview of operation
// R1 - polarity 1 adds random offset positively
// R2 - polarity 0 subtracts random offset
// R3 - controller averages two opposite-polarity readings
// R4 - track-hold samples last sense at switch-off
// R5 - held sample keeps polarity active at switch-off
// R6 - polarity writes while off leave output unchanged
// R7 - controller turns channel on before second reading
// R8 - controller spaces readings about five time constants
// R9 - normal mode hot ground sets prewarn flag
// R10 - prewarn flag never switches a channel off
// R11 - flag clears on fault read once cool
// R12 - status reports channel states, bits zero, one
// R13 - on-state bit follows half-supply output comparator
// R14 - on-state may differ from drive under faults
// R15 - track-hold enable picks synchronous or hold mode
// R16 - polarity affects own channel from next on-period
module sense_offset_status_logic (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] ch_drive_cmd,
	input wire logic [1:0] offset_polarity_sel,
	input wire logic track_hold_en,
	input wire logic csns0_en,
	input wire logic csns1_en,
	input wire logic normal_mode,
	input sense_pkg::load_t load_current_ch0,
	input sense_pkg::load_t load_current_ch1,
	input sense_pkg::offs_t rand_offset_ch0,
	input sense_pkg::offs_t rand_offset_ch1,
	input sense_pkg::sense_t temp_sense_value,
	input wire logic [`FAULT_OTHER_W-1:0] fault_flags_in,
	input wire logic fault_report_rd,
	input wire logic temp_above_prewarn,
	input wire logic [1:0] out_above_half_supply,
	output sense_pkg::sense_t sense_out,
	output logic sense_valid_n,
	output logic [1:0] channel_drive,
	output logic temp_prewarn_flag,
	output logic [`FAULT_W-1:0] fault_report_reg,
	output logic [`STAT_W-1:0] status_report_reg
);
	import sense_pkg::*;

	// synchronised pin levels
	logic [2:0] pins_s;
	logic hot_s;
	logic [1:0] above_s;

	// per-channel sense values
	logic [1:0] ch_on;
	sense_t mirror_ch0;
	sense_t mirror_ch1;

	// shared sense output state
	sense_src_e src;
	sense_src_e src_q;
	sense_src_e next_src_q;
	sense_state_e state;
	sense_state_e next_state;
	settle_cnt_t settle_cnt;
	settle_cnt_t next_settle_cnt;
	sense_t next_sense_out;
	logic next_sense_valid_n;
	logic sel_on;
	sense_t sel_mirror;
	logic hold_mode;

	// reporting state
	logic [1:0] next_channel_drive;
	logic next_temp_prewarn_flag;
	logic [`FAULT_W-1:0] next_fault_report_reg;
	logic [`STAT_W-1:0] next_status_report_reg;

	// comparator and temperature levels come from analog pins
	level_sync #(
		.W(3)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.d({temp_above_prewarn, out_above_half_supply}),
		.q(pins_s)
	);

	assign hot_s = pins_s[2];
	assign above_s = pins_s[1:0];

	// each channel sees only its own polarity bit
	sense_channel u_ch0 (
		.sys_clk(sys_clk),
		.rst(rst),
		.drive_on(ch_drive_cmd[0]),
		.polarity_sel(offset_polarity_sel[0]), // R16
		.load_current(load_current_ch0),
		.rand_offset(rand_offset_ch0),
		.on_state(ch_on[0]),
		.mirror(mirror_ch0)
	);

	sense_channel u_ch1 (
		.sys_clk(sys_clk),
		.rst(rst),
		.drive_on(ch_drive_cmd[1]),
		.polarity_sel(offset_polarity_sel[1]), // R16
		.load_current(load_current_ch1),
		.rand_offset(rand_offset_ch1),
		.on_state(ch_on[1]),
		.mirror(mirror_ch1)
	);

	// route the selected channel onto the shared output path
	always_comb
	begin
		src = sense_src_e'({csns1_en, csns0_en});
		hold_mode = (track_hold_en == `TH_ENABLED); // R15
		if (src == SRC_CH1)
		begin
			sel_on = ch_on[1];
			sel_mirror = mirror_ch1;
		end
		else
		begin
			sel_on = ch_on[0];
			sel_mirror = mirror_ch0;
		end
	end

	// shared sense output: one hold store, so a source change empties it
	always_comb
	begin
		next_state = state;
		next_settle_cnt = settle_cnt;
		next_sense_out = sense_out;
		next_sense_valid_n = `SENSE_IDLE_LVL;
		next_src_q = src;
		if (src != src_q)
		begin
			next_state = ST_IDLE;
			next_sense_out = `SENSE_ZERO;
		end
		else if (src == SRC_TEMP)
		begin
			next_state = ST_IDLE;
			next_sense_out = temp_sense_value;
		end
		else if (src == SRC_OFF)
		begin
			next_state = ST_IDLE;
			next_sense_out = `SENSE_ZERO;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					next_sense_out = `SENSE_ZERO;
					if (sel_on)
					begin
						next_state = ST_SETTLE;
						next_settle_cnt = `SETTLE_CYCLES - `SETTLE_ONE;
					end
				end
				ST_SETTLE:
				begin
					// hold mode leaves the output alone until the mirror has settled
					// sync mode never shows an old held value while settling
					if (!hold_mode)
					begin
						next_sense_out = `SENSE_ZERO; // R15
					end
					if (!sel_on)
					begin
						next_state = hold_mode ? ST_HOLD : ST_IDLE; // R15
					end
					else if (settle_cnt == `SETTLE_DONE)
					begin
						next_state = ST_VALID;
						next_sense_out = sel_mirror;
						next_sense_valid_n = `SENSE_VALID_LVL;
					end
					else
					begin
						next_settle_cnt = settle_cnt - `SETTLE_ONE;
					end
				end
				ST_VALID:
				begin
					if (sel_on)
					begin
						next_sense_out = sel_mirror; // R4
						next_sense_valid_n = `SENSE_VALID_LVL;
					end
					else if (hold_mode)
					begin
						// last on-period value stays, with its own polarity
						next_state = ST_HOLD; // R4 R5
					end
					else
					begin
						next_state = ST_IDLE; // R15
						next_sense_out = `SENSE_ZERO;
					end
				end
				ST_HOLD:
				begin
					// polarity writes cannot reach the held value
					if (!hold_mode)
					begin
						next_state = ST_IDLE; // R15
						next_sense_out = `SENSE_ZERO;
					end
					else if (sel_on)
					begin
						next_state = ST_SETTLE; // R6
						next_settle_cnt = `SETTLE_CYCLES - `SETTLE_ONE;
					end
				end
				default:
				begin
					next_state = ST_IDLE;
					next_sense_out = `SENSE_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			src_q <= SRC_OFF;
			settle_cnt <= `SETTLE_DONE;
			sense_out <= `SENSE_ZERO;
			sense_valid_n <= `SENSE_IDLE_LVL;
		end
		else
		begin
			state <= next_state;
			src_q <= next_src_q;
			settle_cnt <= next_settle_cnt;
			sense_out <= next_sense_out;
			sense_valid_n <= next_sense_valid_n;
		end
	end

	// prewarning, fault report and real-time channel states
	always_comb
	begin
		// drive follows the command; the prewarning never gates it
		next_channel_drive = ch_drive_cmd; // R10
		next_temp_prewarn_flag = temp_prewarn_flag;
		if (fault_report_rd && !hot_s)
		begin
			next_temp_prewarn_flag = 1'b0; // R11
		end
		// set wins over a read in the same cycle
		if (normal_mode && hot_s)
		begin
			next_temp_prewarn_flag = 1'b1; // R9
		end
		next_fault_report_reg = '0;
		next_fault_report_reg[`FAULT_OTHER_W-1:0] = fault_flags_in;
		next_fault_report_reg[`FAULT_PREWARN_BIT] = next_temp_prewarn_flag; // R9
		// comparator view, not drive command: open load at low supply differs
		next_status_report_reg = '0;
		next_status_report_reg[`STAT_CH0_BIT] = above_s[0]; // R12 R13 R14
		next_status_report_reg[`STAT_CH1_BIT] = above_s[1]; // R12 R13 R14
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			channel_drive <= 2'h0;
			temp_prewarn_flag <= 1'b0;
			fault_report_reg <= '0;
			status_report_reg <= '0;
		end
		else
		begin
			channel_drive <= next_channel_drive;
			temp_prewarn_flag <= next_temp_prewarn_flag;
			fault_report_reg <= next_fault_report_reg;
			status_report_reg <= next_status_report_reg;
		end
	end
endmodule

//--- tb/sense_offset_status_sva.sv
`timescale 1ns/1ps
`include "sense_consts.svh"

// watches sense, prewarn and status timing at the top ports
module sense_offset_status_sva (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] ch_drive_cmd,
	input wire logic [1:0] offset_polarity_sel,
	input wire logic track_hold_en,
	input wire logic csns0_en,
	input wire logic csns1_en,
	input wire logic normal_mode,
	input sense_pkg::load_t load_current_ch0,
	input sense_pkg::load_t load_current_ch1,
	input sense_pkg::offs_t rand_offset_ch0,
	input sense_pkg::offs_t rand_offset_ch1,
	input sense_pkg::sense_t temp_sense_value,
	input wire logic [`FAULT_OTHER_W-1:0] fault_flags_in,
	input wire logic fault_report_rd,
	input wire logic temp_above_prewarn,
	input wire logic [1:0] out_above_half_supply,
	input sense_pkg::sense_t sense_out,
	input wire logic sense_valid_n,
	input wire logic [1:0] channel_drive,
	input wire logic temp_prewarn_flag,
	input wire logic [`FAULT_W-1:0] fault_report_reg,
	input wire logic [`STAT_W-1:0] status_report_reg
);
	import sense_pkg::*;

	// one clock domain, so one clocking and one disable for all
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	drive_copy_a: assert property (!$past(rst) |-> channel_drive == $past(ch_drive_cmd))
		else $error("drive output not a copy of the command");
	status_track_a: assert property (!$past(rst, 3) |->
		status_report_reg == $past(out_above_half_supply, 3))
		else $error("status bits do not follow the comparators");
	prewarn_set_a: assert property ((temp_above_prewarn && normal_mode)[*4] |=>
		temp_prewarn_flag)
		else $error("prewarn flag not set while hot");
	prewarn_keep_a: assert property (temp_prewarn_flag && !fault_report_rd |=>
		temp_prewarn_flag)
		else $error("prewarn flag dropped without a read");
	prewarn_clear_a: assert property ((!temp_above_prewarn)[*4] ##0 fault_report_rd |=>
		!temp_prewarn_flag)
		else $error("prewarn flag not cleared by a cool read");
	fault_bit_a: assert property (fault_report_reg[8] == temp_prewarn_flag)
		else $error("fault bit eight differs from the flag");
	// a source change empties the hold, so it is excluded here
	hold_keep_a: assert property ($rose(sense_valid_n) && track_hold_en
		&& $past(track_hold_en) && $past(csns0_en) == $past(csns0_en, 2)
		&& $past(csns1_en) == $past(csns1_en, 2) |-> $stable(sense_out))
		else $error("held sense value changed at switch-off");
	sync_zero_a: assert property (!track_hold_en && !$past(track_hold_en)
		&& sense_valid_n && (csns0_en ^ csns1_en) && $stable({csns1_en, csns0_en})
		|-> sense_out == 13'h0000)
		else $error("sync mode shows a value while not valid");
	settle_wait_a: assert property ($fell(sense_valid_n) |->
		($past(ch_drive_cmd, 300) & {csns1_en, csns0_en}) != 2'h0)
		else $error("sense valid without a settled on-period");
endmodule

bind sense_offset_status_logic sense_offset_status_sva chk (.*);

//--- tb/mcu_avg_model.sv
`timescale 1ns/1ps

// far-side controller: keeps the two newest readings and averages them
module mcu_avg_model (
	input wire logic sys_clk,
	input wire logic take,
	input sense_pkg::sense_t sense_out,
	output logic [13:0] avg
);
	import sense_pkg::*;
	sense_t first;
	sense_t second;

	// opposite offsets cancel in the mean of the two readings
	always @(posedge sys_clk)
		if (take)
		begin
			second <= first;
			first <= sense_out;
		end
	assign avg = ({1'b0, first} + {1'b0, second}) >> 1;
endmodule

//--- tb/sense_offset_status_logic_tb.sv
`timescale 1ns/1ps

module sense_offset_status_logic_tb;
	import sense_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] ch_drive_cmd = 2'h0;
	logic [1:0] offset_polarity_sel = 2'h0;
	logic track_hold_en = 1'b1;
	logic csns0_en = 1'b0;
	logic csns1_en = 1'b0;
	logic normal_mode = 1'b1;
	load_t load_current_ch0 = 12'h064;
	load_t load_current_ch1 = 12'h005;
	offs_t rand_offset_ch0 = 8'h0a;
	offs_t rand_offset_ch1 = 8'hec; // minus twenty
	sense_t temp_sense_value = 13'h0abc;
	logic [7:0] fault_flags_in = 8'ha5;
	logic fault_report_rd = 1'b0;
	logic temp_above_prewarn = 1'b0;
	logic [1:0] out_above_half_supply = 2'h0;
	sense_t sense_out;
	logic sense_valid_n;
	logic [1:0] channel_drive;
	logic temp_prewarn_flag;
	logic [8:0] fault_report_reg;
	logic [1:0] status_report_reg;
	logic take = 1'b0;
	logic [13:0] avg;
	int fail_count = 0;
	int compares = 0;

	sense_offset_status_logic DUT (.*);
	mcu_avg_model mcu (.sys_clk(sys_clk), .take(take), .sense_out(sense_out), .avg(avg));

	// 200 MHz clock
	initial
	begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task conclude;
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// one on-period: wait bounded for valid, take a reading, switch off
	task run(input int ch, input logic [1:0] pol, input logic [12:0] on_v, off_v);
		int n;
		n = 0;
		offset_polarity_sel = pol;
		csns0_en = (ch == 0);
		csns1_en = (ch == 1);
		tick(1);
		ch_drive_cmd[ch] = 1'b1;
		while (sense_valid_n !== 1'b0 && n < 600)
		begin
			tick(1);
			n++;
		end
		tick(2);
		chk(sense_valid_n, 1'b0);
		chk(sense_out, on_v);
		take = 1'b1;
		tick(1);
		take = 1'b0;
		ch_drive_cmd[ch] = 1'b0;
		tick(4);
		chk(sense_out, off_v);
		chk(sense_valid_n, 1'b1);
	endtask

	task read_fault;
		fault_report_rd = 1'b1;
		tick(1);
		fault_report_rd = 1'b0;
	endtask

	// main sequence
	initial
	begin
		tick(5);
		rst = 1'b0;
		tick(2);
		chk(sense_valid_n, 1'b1);
		run(0, 2'b01, 13'h006e, 13'h006e);
		offset_polarity_sel = 2'b10;
		tick(5);
		chk(sense_out, 13'h006e);
		run(0, 2'b10, 13'h005a, 13'h005a);
		chk(avg, 14'h0064);
		run(1, 2'b10, 13'h0000, 13'h0000);
		run(1, 2'b00, 13'h0019, 13'h0019);
		track_hold_en = 1'b0;
		run(0, 2'b01, 13'h006e, 13'h0000);
		// temperature source: one edge to empty, one to show the value
		csns0_en = 1'b1;
		csns1_en = 1'b1;
		tick(3);
		chk(sense_out, 13'h0abc);
		chk(sense_valid_n, 1'b1);
		out_above_half_supply = 2'b10;
		tick(4);
		chk(status_report_reg, 2'b10);
		out_above_half_supply = 2'b01;
		tick(4);
		chk(status_report_reg, 2'b01);
		ch_drive_cmd = 2'b11;
		temp_above_prewarn = 1'b1;
		tick(5);
		chk(temp_prewarn_flag, 1'b1);
		chk(channel_drive, 2'b11);
		chk(fault_report_reg, 9'h1a5);
		read_fault();
		chk(temp_prewarn_flag, 1'b1);
		temp_above_prewarn = 1'b0;
		tick(4);
		chk(temp_prewarn_flag, 1'b1);
		read_fault();
		chk(temp_prewarn_flag, 1'b0);
		normal_mode = 1'b0;
		temp_above_prewarn = 1'b1;
		tick(6);
		chk(temp_prewarn_flag, 1'b0);
		conclude();
	end

	// watchdog: about ten times the expected run length
	initial
	begin
		#100000;
		fail_count++;
		conclude();
	end
endmodule
